// *** rtl/ssc_map.vh ***
// Bit map, codes and timing constants of the synthesizer serial control block
`ifndef SSC_MAP_VH
`define SSC_MAP_VH

// Serial word and latch-select codes in the two low bits
`define SSC_WORD_W       24
`define SSC_SEL_MSB      1
`define SSC_SEL_LSB      0
`define SSC_SEL_CTRL     2'h0
`define SSC_SEL_REF      2'h1
`define SSC_SEL_FB       2'h2
`define SSC_SEL_TEST     2'h3

// Latch reset values
`define SSC_CTRL_RST     24'h000000
`define SSC_REF_RST      24'h000001
`define SSC_FB_RST       24'h000002
`define SSC_TEST_RST     24'h000003

// Control latch fields
`define SSC_C_PRE_MSB    23
`define SSC_C_PRE_LSB    22
`define SSC_C_PD2        21
`define SSC_C_PD1        20
`define SSC_C_CPI_MSB    19
`define SSC_C_CPI_LSB    14
`define SSC_C_LVL_MSB    13
`define SSC_C_LVL_LSB    12
`define SSC_C_MUTE       11
`define SSC_C_CPG        10
`define SSC_C_CPTRI      9
`define SSC_C_POL        8
`define SSC_C_MUX_MSB    7
`define SSC_C_MUX_LSB    5
`define SSC_C_CRST       4
`define SSC_C_CORE_MSB   3
`define SSC_C_CORE_LSB   2

// Feedback counter latch fields
`define SSC_N_DIVSEL     23
`define SSC_N_HALVE      22
`define SSC_N_CPG        21
`define SSC_N_B_MSB      20
`define SSC_N_B_LSB      8
`define SSC_N_A_MSB      6
`define SSC_N_A_LSB      2

// Reference counter latch fields
`define SSC_R_BSC_MSB    21
`define SSC_R_BSC_LSB    20
`define SSC_R_TMB        19
`define SSC_R_LDP        18
`define SSC_R_ABP_MSB    17
`define SSC_R_ABP_LSB    16
`define SSC_R_CNT_MSB    15
`define SSC_R_CNT_LSB    2

// Prescaler modulus codes
`define SSC_PRE_8        2'h0
`define SSC_PRE_16       2'h1
`define SSC_P8           6'h08
`define SSC_P16          6'h10
`define SSC_P32          6'h20

// Output multiplexer codes
`define SSC_MUX_OFF      3'h0
`define SSC_MUX_DLD      3'h1
`define SSC_MUX_FB       3'h2
`define SSC_MUX_HIGH     3'h3
`define SSC_MUX_REF      3'h4
`define SSC_MUX_ALD      3'h5
`define SSC_MUX_SDO      3'h6
`define SSC_MUX_LOW      3'h7

// Timing
`define SSC_CLK_NS       4
`define SSC_LD_SET_NS    15
`define SSC_LD_CLR_NS    25
`define SSC_LD_FEW       3
`define SSC_LD_MANY      5
`define SSC_BS_CYCLES    5

`endif

// *** rtl/ssc_div.v ***
// Programmable tick divider: one output tick per modulus input ticks
`timescale 1ns/1ns
module ssc_div #(
  parameter W = 14
) (
  input  wire         sys_clk,
  input  wire         sys_rst,
  input  wire         clear,
  input  wire         tick_in,
  input  wire [W-1:0] modulus,
  output wire         tick_out
);
  reg [W-1:0] cnt_reg;
  reg         tick_reg;
  wire        at_end;

  // A modulus of zero behaves as one so the chain never stalls
  assign at_end   = (modulus == {W{1'b0}}) || (cnt_reg >= modulus - {{(W-1){1'b0}}, 1'b1});
  assign tick_out = tick_reg;

  // Count input ticks and pulse on the last one
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg  <= {W{1'b0}};
      tick_reg <= 1'b0;
    end else if (clear) begin
      cnt_reg  <= {W{1'b0}};
      tick_reg <= 1'b0;
    end else if (tick_in) begin
      cnt_reg  <= at_end ? {W{1'b0}} : cnt_reg + {{(W-1){1'b0}}, 1'b1};
      tick_reg <= at_end;
    end else begin
      tick_reg <= 1'b0;
    end
  end
endmodule

// *** rtl/ssc_lock.v ***
// Phase error measurement and digital lock detector
`timescale 1ns/1ns
`include "ssc_map.vh"
module ssc_lock (
  input  wire sys_clk,
  input  wire sys_rst,
  input  wire clear,
  input  wire ref_tick,
  input  wire fb_tick,
  input  wire precision,
  output wire locked,
  output wire err_active
);
  // Longest error still good (under the set limit) and longest error not bad
  localparam [7:0] GOOD_MAX = (`SSC_LD_SET_NS + `SSC_CLK_NS - 1) / `SSC_CLK_NS - 1;
  localparam [7:0] BAD_MAX  = `SSC_LD_CLR_NS / `SSC_CLK_NS;
  localparam [2:0] NEED_FEW  = `SSC_LD_FEW;
  localparam [2:0] NEED_MANY = `SSC_LD_MANY;

  reg        meas_reg;
  reg        ref_first_reg;
  reg  [7:0] err_reg;
  reg  [2:0] good_reg;
  reg        lock_reg;
  reg        done;
  reg  [7:0] err_val;
  wire [2:0] need;

  assign need       = precision ? NEED_MANY : NEED_FEW;
  assign locked     = lock_reg;
  assign err_active = meas_reg;

  // A cycle ends when the edge of the other input arrives
  always @* begin
    done    = 1'b0;
    err_val = 8'h00;
    if (!meas_reg && ref_tick && fb_tick) begin
      done = 1'b1;
    end else if (meas_reg && (ref_first_reg ? fb_tick : ref_tick)) begin
      done    = 1'b1;
      err_val = err_reg;
    end
  end

  // Measure, count good cycles, set and drop lock
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meas_reg      <= 1'b0;
      ref_first_reg <= 1'b0;
      err_reg       <= 8'h00;
      good_reg      <= 3'h0;
      lock_reg      <= 1'b0;
    end else if (clear) begin
      meas_reg <= 1'b0;
      err_reg  <= 8'h00;
      good_reg <= 3'h0;
      lock_reg <= 1'b0;
    end else begin
      if (done) begin
        meas_reg <= 1'b0;
        err_reg  <= 8'h00;
      end else if (!meas_reg && (ref_tick || fb_tick)) begin
        meas_reg      <= 1'b1;
        ref_first_reg <= ref_tick;
        err_reg       <= 8'h01;
      end else if (meas_reg && err_reg != 8'hff) begin
        err_reg <= err_reg + 8'h01;
      end
      if (done) begin
        if (err_val <= GOOD_MAX) begin
          good_reg <= (good_reg < need) ? good_reg + 3'h1 : good_reg;
          if (good_reg + 3'h1 >= need)
            lock_reg <= 1'b1;
        end else begin
          good_reg <= 3'h0;
        end
        if (lock_reg && err_val > BAD_MAX)
          lock_reg <= 1'b0;
      end
      // An open measurement already past the limit is a bad cycle, even if the partner edge never comes
      if (lock_reg && meas_reg && err_reg > BAD_MAX)
        lock_reg <= 1'b0;
    end
  end
endmodule

// *** rtl/ssc_synth_ctrl.v ***
// Synthesizer digital control: serial port, latches, dividers, lock, band select
`timescale 1ns/1ns
`include "ssc_map.vh"
module ssc_synth_ctrl #(
  parameter RCNT_W = 14,
  parameter BCNT_W = 13,
  parameter ACNT_W = 5
) (
  input  wire       sys_clk,
  input  wire       sys_rst,
  input  wire       serial_clock,
  input  wire       serial_data,
  input  wire       load_strobe,
  input  wire       chip_enable,
  input  wire       reference_input,
  input  wire       vco_input,
  output wire       multiplexed_test_output,
  output wire       multiplexed_test_output_oe,
  output wire       tuning_hold,
  output wire       cp_three_state,
  output wire       rf_output_enable,
  output wire       halve_output,
  output wire       halve_select,
  output wire       digital_lock,
  output wire       pfd_ref_tick,
  output wire       pfd_fb_tick,
  output wire [1:0] antibacklash_width,
  output wire [1:0] core_current,
  output wire [1:0] output_level,
  output wire [5:0] cp_current,
  output wire       cp_gain,
  output wire       pfd_polarity
);
  reg  [23:0] shift_reg;
  reg  [23:0] ctrl_reg;
  reg  [23:0] ref_reg;
  reg  [23:0] fb_reg;
  reg  [23:0] test_reg;
  reg         sclk_d_reg;
  reg         load_d_reg;
  reg         ref_d_reg;
  reg         vco_d_reg;
  reg         fb_write_reg;
  reg  [5:0]  pre_cnt_reg;
  reg  [BCNT_W-1:0] b_cnt_reg;
  reg  [ACNT_W-1:0] a_cnt_reg;
  reg         fb_tick_reg;
  reg         bs_pend_reg;
  reg         bs_act_reg;
  reg  [2:0]  bs_cnt_reg;
  reg         ref_sq_reg;
  reg         fb_sq_reg;
  reg         mux_reg;
  reg         mux_oe_reg;
  reg         mux_next;
  reg         mux_oe_next;
  reg         cp_tri_reg;
  reg         rf_en_reg;
  reg  [5:0]  p_mod;
  wire        sclk_rise;
  wire        load_rise;
  wire        ref_edge;
  wire        vco_edge;
  wire        powered;
  wire        cnt_clear;
  wire        pre_out;
  wire        swallow;
  wire        pre_end;
  wire        b_end;
  wire        r_tick;
  wire        bs_tick;
  wire        locked;
  wire        err_active;
  wire [3:0]  bs_mod;
  wire [BCNT_W-1:0] b_val;
  wire [ACNT_W-1:0] a_val;
  wire [2:0]  mux_sel;

  // Pins are synchronous; rising edges come from one stage of history
  assign sclk_rise = serial_clock & ~sclk_d_reg;
  assign load_rise = load_strobe & ~load_d_reg;
  assign ref_edge  = reference_input & ~ref_d_reg;
  assign vco_edge  = vco_input & ~vco_d_reg;

  // Hardware enable and either software power-down bit (PD1 or PD2) stop the core
  assign powered   = chip_enable & ~ctrl_reg[`SSC_C_PD1] & ~ctrl_reg[`SSC_C_PD2];
  assign cnt_clear = ~powered | ctrl_reg[`SSC_C_CRST];

  // Latch fields straight out to the analog side, the mux select and the B and A counters
  assign antibacklash_width = ref_reg[`SSC_R_ABP_MSB:`SSC_R_ABP_LSB];
  assign core_current       = ctrl_reg[`SSC_C_CORE_MSB:`SSC_C_CORE_LSB];
  assign output_level       = ctrl_reg[`SSC_C_LVL_MSB:`SSC_C_LVL_LSB];
  assign halve_output       = fb_reg[`SSC_N_HALVE];
  assign halve_select       = fb_reg[`SSC_N_DIVSEL];
  assign cp_current         = ctrl_reg[`SSC_C_CPI_MSB:`SSC_C_CPI_LSB];
  assign cp_gain            = ctrl_reg[`SSC_C_CPG];
  assign pfd_polarity       = ctrl_reg[`SSC_C_POL];
  assign mux_sel            = ctrl_reg[`SSC_C_MUX_MSB:`SSC_C_MUX_LSB];
  assign b_val              = fb_reg[`SSC_N_B_MSB:`SSC_N_B_LSB];
  assign a_val              = fb_reg[`SSC_N_A_MSB:`SSC_N_A_LSB];

  // Registered outputs
  assign multiplexed_test_output    = mux_reg;
  assign multiplexed_test_output_oe = mux_oe_reg;
  assign tuning_hold                = bs_act_reg;
  assign cp_three_state             = cp_tri_reg;
  assign rf_output_enable           = rf_en_reg;
  assign digital_lock               = locked;
  assign pfd_ref_tick               = r_tick;
  assign pfd_fb_tick                = fb_tick_reg;

  // Edge history of the synchronous pins
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_d_reg <= 1'b0;
      load_d_reg <= 1'b0;
      ref_d_reg  <= 1'b0;
      vco_d_reg  <= 1'b0;
    end else begin
      sclk_d_reg <= serial_clock;
      load_d_reg <= load_strobe;
      ref_d_reg  <= reference_input;
      vco_d_reg  <= vco_input;
    end
  end

  // Shift register and latch transfer; the word's low bits pick the target
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      shift_reg    <= 24'h000000;
      ctrl_reg     <= `SSC_CTRL_RST;
      ref_reg      <= `SSC_REF_RST;
      fb_reg       <= `SSC_FB_RST;
      test_reg     <= `SSC_TEST_RST;
      fb_write_reg <= 1'b0;
    end else begin
      fb_write_reg <= 1'b0;
      if (sclk_rise)
        shift_reg <= {shift_reg[22:0], serial_data};
      if (load_rise) begin
        case (shift_reg[`SSC_SEL_MSB:`SSC_SEL_LSB])
          `SSC_SEL_CTRL: ctrl_reg <= shift_reg;
          `SSC_SEL_REF:  ref_reg  <= shift_reg;
          `SSC_SEL_FB: begin
            fb_reg       <= shift_reg;
            fb_write_reg <= 1'b1;
          end
          default: test_reg <= shift_reg; // Kept but steers nothing
        endcase
      end
    end
  end

  // Reference divider; ratio zero is treated as one
  ssc_div #(
    .W (RCNT_W)
  ) u_ref_div (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .clear    (cnt_clear),
    .tick_in  (ref_edge),
    .modulus  (ref_reg[`SSC_R_CNT_MSB:`SSC_R_CNT_LSB]),
    .tick_out (r_tick)
  );

  // Band select clock prescaler: 1, 2, 4 or 8 reference periods
  assign bs_mod = 4'h1 << ref_reg[`SSC_R_BSC_MSB:`SSC_R_BSC_LSB];
  ssc_div #(
    .W (4)
  ) u_bs_div (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .clear    (cnt_clear),
    .tick_in  (r_tick),
    .modulus  (bs_mod),
    .tick_out (bs_tick)
  );

  // Prescaler modulus from the control latch
  always @* begin
    case (ctrl_reg[`SSC_C_PRE_MSB:`SSC_C_PRE_LSB])
      `SSC_PRE_8:  p_mod = `SSC_P8;
      `SSC_PRE_16: p_mod = `SSC_P16;
      default:     p_mod = `SSC_P32;
    endcase
  end

  // Dual modulus prescaler: P+1 while the swallow counter still runs
  assign swallow = a_cnt_reg < a_val;
  assign pre_end = swallow ? (pre_cnt_reg >= p_mod) : (pre_cnt_reg >= p_mod - 6'h01);
  assign pre_out = vco_edge & pre_end;
  assign b_end   = (b_cnt_reg >= b_val - {{(BCNT_W-1){1'b0}}, 1'b1}) || (b_val == {BCNT_W{1'b0}});

  // B counts prescaler periods, A swallows one extra input per count
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_cnt_reg <= 6'h00;
      b_cnt_reg   <= {BCNT_W{1'b0}};
      a_cnt_reg   <= {ACNT_W{1'b0}};
      fb_tick_reg <= 1'b0;
    end else if (cnt_clear) begin
      pre_cnt_reg <= 6'h00;
      b_cnt_reg   <= {BCNT_W{1'b0}};
      a_cnt_reg   <= {ACNT_W{1'b0}};
      fb_tick_reg <= 1'b0;
    end else begin
      fb_tick_reg <= 1'b0;
      if (vco_edge)
        pre_cnt_reg <= pre_end ? 6'h00 : pre_cnt_reg + 6'h01;
      if (pre_out) begin
        if (b_end) begin
          b_cnt_reg   <= {BCNT_W{1'b0}};
          a_cnt_reg   <= {ACNT_W{1'b0}};
          fb_tick_reg <= 1'b1;
        end else begin
          b_cnt_reg <= b_cnt_reg + {{(BCNT_W-1){1'b0}}, 1'b1};
          if (swallow)
            a_cnt_reg <= a_cnt_reg + {{(ACNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // Phase error and lock detection on the two divided edges
  ssc_lock u_lock (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .clear      (cnt_clear | bs_act_reg),
    .ref_tick   (r_tick),
    .fb_tick    (fb_tick_reg),
    .precision  (ref_reg[`SSC_R_LDP]),
    .locked     (locked),
    .err_active (err_active)
  );

  // Band select: pending from power-up, re-armed by every feedback write;
  // a write landing as a run starts keeps the request alive
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bs_pend_reg <= 1'b1;
      bs_act_reg  <= 1'b0;
      bs_cnt_reg  <= 3'h0;
    end else begin
      bs_pend_reg <= fb_write_reg | (bs_pend_reg & ~(powered & ~bs_act_reg));
      if (!powered) begin
        bs_act_reg <= 1'b0;
        bs_cnt_reg <= 3'h0;
      end else if (!bs_act_reg && bs_pend_reg) begin
        bs_act_reg <= 1'b1;
        bs_cnt_reg <= 3'h0;
      end else if (bs_act_reg && bs_tick) begin
        if (bs_cnt_reg == `SSC_BS_CYCLES - 1)
          bs_act_reg <= 1'b0;
        bs_cnt_reg <= bs_cnt_reg + 3'h1;
      end
    end
  end

  // Output multiplexer; the analog lock code drives low only (open drain)
  always @* begin
    mux_next    = 1'b0;
    mux_oe_next = 1'b1;
    case (mux_sel)
      `SSC_MUX_OFF:  mux_oe_next = 1'b0;
      `SSC_MUX_DLD:  mux_next = locked;
      `SSC_MUX_FB:   mux_next = fb_sq_reg;
      `SSC_MUX_HIGH: mux_next = 1'b1;
      `SSC_MUX_REF:  mux_next = ref_sq_reg;
      `SSC_MUX_ALD:  mux_oe_next = err_active;
      `SSC_MUX_SDO:  mux_next = shift_reg[23];
      `SSC_MUX_LOW:  mux_next = 1'b0;
      default:       mux_oe_next = 1'b0;
    endcase
  end

  // Scaled divider outputs are half-rate squares so a scope can see them
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_sq_reg <= 1'b0;
      fb_sq_reg  <= 1'b0;
      mux_reg    <= 1'b0;
      mux_oe_reg <= 1'b0;
      cp_tri_reg <= 1'b1;
      rf_en_reg  <= 1'b0;
    end else begin
      if (r_tick)
        ref_sq_reg <= ~ref_sq_reg;
      if (fb_tick_reg)
        fb_sq_reg <= ~fb_sq_reg;
      mux_reg    <= mux_next;
      mux_oe_reg <= mux_oe_next;
      cp_tri_reg <= ~powered | ctrl_reg[`SSC_C_CPTRI];
      rf_en_reg  <= powered & (~ctrl_reg[`SSC_C_MUTE] | locked);
    end
  end
endmodule

// *** sim/ssc_host.sv ***
// Host model that drives the three-wire serial port
`timescale 1ns/1ns
module ssc_host (
  input  wire  sys_clk,
  output logic serial_clock,
  output logic serial_data,
  output logic load_strobe
);
  initial begin
    serial_clock = 1'b0;
    serial_data  = 1'b0;
    load_strobe  = 1'b0;
  end
  // Three cycles per level, safely above the two-sample minimum
  task automatic hold3();
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  // Callers never address the test latch; the word goes out whole
  task automatic send_word(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      serial_data = w[i];
      hold3();
      serial_clock = 1'b1;
      hold3();
      serial_clock = 1'b0;
    end
    hold3();
    load_strobe = 1'b1;
    hold3();
    load_strobe = 1'b0;
    serial_data = ~serial_data; // Idle line shows no stale bit
  endtask
endmodule

// *** sim/ssc_synth_ctrl_assertions.sv ***
// Port checker of the synthesizer control block
`timescale 1ns/1ns
module ssc_synth_ctrl_assertions (
  input wire sys_clk,
  input wire sys_rst,
  input wire chip_enable,
  input wire reference_input,
  input wire vco_input,
  input wire tuning_hold,
  input wire cp_three_state,
  input wire rf_output_enable,
  input wire digital_lock,
  input wire pfd_ref_tick,
  input wire pfd_fb_tick
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Three samples low leave room for the registered power path
  sequence s_off3;
    !chip_enable [*3];
  endsequence
  sequence s_band3;
    tuning_hold [*3];
  endsequence
  property p_pd_pump;
    s_off3 |-> cp_three_state;
  endproperty
  property p_pd_rf;
    s_off3 |-> !rf_output_enable;
  endproperty
  property p_band_lock;
    s_band3 |-> !digital_lock;
  endproperty
  property p_ref_pulse;
    pfd_ref_tick |=> !pfd_ref_tick;
  endproperty
  property p_fb_pulse;
    pfd_fb_tick |=> !pfd_fb_tick;
  endproperty
  property p_ref_cause;
    pfd_ref_tick |-> $past(reference_input) && !$past(reference_input, 2);
  endproperty
  property p_fb_cause;
    pfd_fb_tick |-> $past(vco_input) && !$past(vco_input, 2);
  endproperty
  property p_lock_cause;
    $rose(digital_lock) |-> $past(pfd_ref_tick || pfd_fb_tick);
  endproperty
  a_pd_pump: assert property (p_pd_pump) else $error("pump active while disabled");
  a_pd_rf: assert property (p_pd_rf) else $error("output stage on while disabled");
  a_band_lock: assert property (p_band_lock) else $error("lock held during band select");
  a_ref_pulse: assert property (p_ref_pulse) else $error("reference tick too long");
  a_fb_pulse: assert property (p_fb_pulse) else $error("feedback tick too long");
  a_ref_cause: assert property (p_ref_cause) else $error("reference tick without edge");
  a_fb_cause: assert property (p_fb_cause) else $error("feedback tick without edge");
  a_lock_cause: assert property (p_lock_cause) else $error("lock set without a tick");
endmodule
bind ssc_synth_ctrl ssc_synth_ctrl_assertions i_chk (.sys_clk, .sys_rst, .chip_enable, .reference_input,
  .vco_input, .tuning_hold, .cp_three_state, .rf_output_enable, .digital_lock, .pfd_ref_tick, .pfd_fb_tick);

// *** sim/ssc_synth_ctrl_bench.sv ***
// Self-checking bench of the synthesizer control block
`timescale 1ns/1ns
module ssc_synth_ctrl_bench;
  logic       sys_clk         = 1'b0;
  logic       sys_rst         = 1'b1;
  logic       chip_enable     = 1'b1;
  logic       reference_input = 1'b0;
  logic       vco_input       = 1'b0;
  logic       osc_run         = 1'b1;
  int         bad_count       = 0;
  int         samples_checked = 0;
  wire        serial_clock, serial_data, load_strobe, tuning_hold, cp_three_state, rf_output_enable;
  wire        multiplexed_test_output, multiplexed_test_output_oe, halve_output, halve_select;
  wire        digital_lock, pfd_ref_tick, pfd_fb_tick, cp_gain, pfd_polarity;
  wire [1:0]  antibacklash_width, core_current, output_level;
  wire [5:0]  cp_current;
  // Feedback word: B of 7, A of 2, halving on; with P of 8 the ratio is 58, above P*P-P
  // Oscillator rises every two cycles, so the prescaler output stays far below its limit
  localparam logic [23:0] FB_WORD = {1'b0, 1'b1, 1'b0, 13'h0007, 1'b0, 5'h02, 2'h2};

  always #2 sys_clk = ~sys_clk;
  // Both inputs rise every two cycles, so equal ratios give aligned ticks
  always @(posedge sys_clk) begin
    #1;
    reference_input <= ~reference_input;
    if (osc_run)
      vco_input <= ~vco_input;
  end

  ssc_host i_host (.sys_clk, .serial_clock, .serial_data, .load_strobe);
  ssc_synth_ctrl i_dut (.sys_clk, .sys_rst, .serial_clock, .serial_data, .load_strobe, .chip_enable,
    .reference_input, .vco_input, .multiplexed_test_output, .multiplexed_test_output_oe, .tuning_hold,
    .cp_three_state, .rf_output_enable, .halve_output, .halve_select, .digital_lock, .pfd_ref_tick,
    .pfd_fb_tick, .antibacklash_width, .core_current, .output_level, .cp_current, .cp_gain, .pfd_polarity);

  // Reference word with a ratio of 58 and band clock divided by one
  function automatic logic [23:0] ref_word(input logic lock_precision);
    return {2'h0, 2'h0, 1'b0, lock_precision, 2'h2, 14'h003a, 2'h1};
  endfunction
  function automatic logic [23:0] ctrl_word(input logic [2:0] mux, input logic mute, input logic cr);
    return {2'h0, 2'h0, 6'h2a, 2'h1, mute, 1'b1, 1'b0, 1'b1, mux, cr, 2'h3, 2'h0};
  endfunction
  task automatic check_bits(input logic [23:0] got, input logic [23:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task automatic check_count(input int got, input int exp, input string what);
    samples_checked++;
    if (got != exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %0d", $time, what, got);
    end
  endtask
  task automatic give_verdict();
    $display("Checks made %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // A wait that used its whole bound ends the run
  task automatic bound_hit(input int i, input int lim);
    if (i >= lim) begin
      bad_count++;
      $display("wrong value at %0t: wait ran out", $time);
      give_verdict();
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic t_reset();
    cyc(8);
    check_bits(cp_three_state, 1'h1, "pump off in reset");
    check_bits({rf_output_enable, digital_lock, multiplexed_test_output_oe}, 3'h0, "outputs idle in reset");
    sys_rst = 1'b0;
    $display("t_reset done");
  endtask
  task automatic t_fields();
    int i;
    i_host.send_word(ref_word(1'b0));
    i_host.send_word(ctrl_word(3'h3, 1'b0, 1'b0));
    cyc(3);
    check_bits(antibacklash_width, 2'h2, "backlash width");
    check_bits(core_current, 2'h3, "core current");
    check_bits(output_level, 2'h1, "output level");
    check_bits({cp_current, cp_gain, pfd_polarity}, 8'hab, "pump fields");
    check_bits({multiplexed_test_output, multiplexed_test_output_oe}, 2'h3, "mux high");
    check_bits(cp_three_state, 1'h0, "pump enabled");
    i_host.send_word(ctrl_word(3'h7, 1'b0, 1'b0));
    cyc(3);
    check_bits({multiplexed_test_output, multiplexed_test_output_oe}, 2'h1, "mux low");
    i_host.send_word(ctrl_word(3'h0, 1'b0, 1'b0));
    cyc(3);
    check_bits({multiplexed_test_output, multiplexed_test_output_oe}, 2'h0, "mux off");
    cyc(10); // the model has no bias settling, so a short pause stands for the interval
    i_host.send_word(FB_WORD);
    check_bits({halve_select, halve_output}, 2'h1, "halve bits");
    check_bits(tuning_hold, 1'h1, "band select started");
    // Five band ticks of 116 cycles, the first one at an unknown phase
    for (i = 0; i < 1000 && tuning_hold === 1'b1; i++)
      cyc(1);
    bound_hit(i, 1000);
    check_count(i >= 460 && i <= 590, 1, "band select length");
    $display("t_fields done");
  endtask
  task automatic t_lock(input logic lock_precision, input int exp);
    int i;
    int n;
    i_host.send_word(ref_word(lock_precision));
    i_host.send_word(ctrl_word(3'h1, 1'b1, 1'b1));
    check_bits(rf_output_enable, 1'h0, "muted before lock");
    i_host.send_word(ctrl_word(3'h1, 1'b1, 1'b0));
    n = 0;
    for (i = 0; i < 2000 && digital_lock !== 1'b1; i++) begin
      if (pfd_ref_tick === 1'b1)
        n++;
      cyc(1);
    end
    bound_hit(i, 2000);
    check_count(n, exp, "good cycles before lock");
    cyc(2);
    check_bits(rf_output_enable, 1'h1, "unmuted at lock");
    check_bits({multiplexed_test_output, multiplexed_test_output_oe}, 2'h3, "mux shows lock");
    for (i = 0; i < 300 && pfd_fb_tick !== 1'b1; i++)
      cyc(1);
    bound_hit(i, 300);
    cyc(1);
    for (n = 1; n < 300 && pfd_fb_tick !== 1'b1; n++)
      cyc(1);
    check_count(n, 116, "feedback period");
    $display("t_lock done");
  endtask
  task automatic t_unlock();
    int i;
    osc_run = 1'b0; // Feedback stops, so the next pair is far apart
    for (i = 0; i < 300 && digital_lock === 1'b1; i++)
      cyc(1);
    check_bits(digital_lock, 1'h0, "lock dropped");
    cyc(2);
    check_bits({multiplexed_test_output, rf_output_enable}, 2'h0, "unlock seen");
    osc_run = 1'b1;
    $display("t_unlock done");
  endtask
  task automatic t_power();
    chip_enable = 1'b0;
    cyc(4);
    check_bits({cp_three_state, rf_output_enable, digital_lock}, 3'h4, "powered down");
    chip_enable = 1'b1;
    $display("t_power done");
  endtask

  initial begin
    #200000;
    bad_count++;
    give_verdict();
  end
  initial begin
    t_reset();
    t_fields();
    t_lock(1'b0, 3);
    t_unlock();
    t_lock(1'b1, 5);
    t_power();
    give_verdict();
  end
endmodule
